// [logic/pattern_matcher.sv]
`timescale 1ns/100ps
`default_nettype none
module pattern_matcher #(
  parameter int MAX_BITS = 64
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic enable_in,
  input wire logic bit_valid_in,
  input wire logic bit_in,
  input wire logic [2:0] length_in,
  input wire logic [2:0] tol_in,
  input wire logic [MAX_BITS-1:0] pattern_in,
  output logic match_out
);
  import radio_pkg::*;

  logic [MAX_BITS-1:0] hist;
  logic [6:0] seen;
  logic check;

  // count of mismatching bits inside the window
  function automatic logic [6:0] ones(input logic [MAX_BITS-1:0] v);
    ones = '0;
    for (int i = 0; i < MAX_BITS; i++) begin
      ones = ones + 7'(v[i]);
    end
  endfunction : ones

  // window is 8 to 64 bits; first pattern byte sits in the top byte
  wire [3:0] nbytes = {1'b0, length_in} + 4'h1;
  wire [6:0] nbits = {nbytes, 3'h0};
  wire [MAX_BITS-1:0] mask = ~({MAX_BITS{1'b1}} << nbits);
  wire [MAX_BITS-1:0] expect_bits = pattern_in >> (7'd64 - nbits);
  wire [6:0] errs = ones((hist ^ expect_bits) & mask);

  // newest bit enters at bit 0, so the oldest meets pattern bit 63
  always_ff @(posedge clk_in) begin
    if (!rstn_in || !enable_in) begin
      hist <= '0;
      seen <= '0;
      check <= 1'b0;
      match_out <= 1'b0;
    end else begin
      check <= bit_valid_in;
      if (bit_valid_in) begin
        hist <= {hist[MAX_BITS-2:0], bit_in};
        seen <= (seen == 7'd64) ? seen : seen + 7'd1;
      end
      // stale history before a full window is never trusted
      match_out <= check && seen >= nbits && errs <= {4'h0, tol_in};
    end
  end
endmodule : pattern_matcher
`default_nettype wire

// [logic/radio_fifo_sync_dio_status.sv]
`timescale 1ns/100ps
`default_nettype none
module radio_fifo_sync_dio_status #(
  parameter int DEPTH = radio_pkg::FIFO_DEPTH
) (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [radio_pkg::ADDR_W-1:0] address_in,
  input wire logic read_in,
  input wire logic write_in,
  input wire logic [31:0] writedata_in,
  input wire logic [3:0] byteenable_in,
  output logic [31:0] readdata_out,
  output logic waitrequest_out,
  input wire logic bit_clk_in,
  input wire logic demod_bit_in,
  output logic mod_bit_out,
  input wire logic ref_clk_in,
  input wire logic mode_settled_in,
  input wire logic synthesizer_locked_in,
  input wire logic receiver_ready_in,
  input wire logic transmitter_ready_in,
  input wire logic rssi_in,
  input wire logic timeout_in,
  input wire logic automatic_sequence_active_in,
  input wire logic gp_pin_2_in,
  output logic gp_pin_0_out,
  output logic gp_pin_1_out,
  output logic gp_pin_2_out,
  output logic gp_pin_2_oe_out,
  output logic gp_pin_3_out,
  output logic gp_pin_4_out,
  output logic gp_pin_5_out
);
  import radio_pkg::*;

  localparam int CW = $clog2(DEPTH + 1);

  // software registers
  logic [2:0] mode;
  logic packet_mode;
  logic bitsync_on;
  logic [6:0] level_threshold;
  logic [7:0] pattern_config;
  logic [63:0] pattern_value;
  logic [7:0] pin_map_a;
  logic [7:0] pin_map_b;

  // buffer state and flags
  logic [7:0] mem [0:DEPTH-1];
  logic [CW-1:0] count;
  logic [CW-1:0] rd_ptr;
  logic [CW-1:0] wr_ptr;
  logic buffer_has_data;
  logic buffer_full_status;
  logic buffer_overrun_flag;
  logic buffer_level_event;
  logic level_stale;
  logic frame_transmitted;
  logic pattern_match_flag;
  logic pattern_match_event;

  // serial shifters
  logic [7:0] tx_sr;
  logic [3:0] tx_left;
  logic [7:0] rx_sr;
  logic [2:0] rx_cnt;
  logic [7:0] rx_byte;
  logic rx_byte_ready;

  // link synchroniser: {pin2 data, ref clock, demod bit, bit clock}
  logic [3:0] lnk_meta;
  logic [3:0] lnk_sync;
  logic lnk_clk_prev;

  // helpers used in more than one place
  function automatic logic [CW-1:0] bump(input logic [CW-1:0] p);
    bump = (p == CW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    merge = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) merge[8*i +: 8] = nw[8*i +: 8];
    end
  endfunction : merge

  function automatic logic pick(input logic [1:0] c, input logic [3:0] v);
    pick = v[c];
  endfunction : pick

  // flush table for mode changes
  function automatic logic must_flush(input logic [2:0] from, input logic [2:0] to);
    must_flush = (from != to) &&
      (((from == MODE_STDBY || from == MODE_SLEEP) && to == MODE_RX) ||
       (from == MODE_RX && to == MODE_TX) || from == MODE_TX);
  endfunction : must_flush

  // mode decode
  wire is_rx = mode == MODE_RX;
  wire is_tx = mode == MODE_TX;
  wire is_fs = mode == MODE_FS;
  wire is_sl = mode == MODE_SLEEP;
  wire bit_rise = lnk_sync[0] & ~lnk_clk_prev;
  wire rx_bit = lnk_sync[1];

  // bus decode: waitrequest drops one cycle after the request appears
  wire req = read_in | write_in;
  wire start = req & waitrequest_out;
  wire done = req & ~waitrequest_out;
  wire wr = done & write_in;
  wire rd = done & read_in;
  wire lo_be = byteenable_in[0];
  wire hit_mode = address_in == OFS_MODE;
  wire hit_fifo = address_in == OFS_FIFO;
  wire hit_status = address_in == OFS_STATUS;
  wire hit_thresh = address_in == OFS_THRESH;
  wire hit_cfg = address_in == OFS_SYNC_CFG;
  wire hit_lo = address_in == OFS_SYNC_LO;
  wire hit_hi = address_in == OFS_SYNC_HI;
  wire hit_map_a = address_in == OFS_MAP_A;
  wire hit_map_b = address_in == OFS_MAP_B;

  // buffer control
  wire empty = count == '0;
  wire full = count == CW'(DEPTH);
  wire fifo_host_wr = wr & hit_fifo & lo_be;
  wire fifo_host_rd = rd & hit_fifo;
  wire ovr_clear = wr & hit_status & lo_be & writedata_in[ST_OVERRUN];
  wire mode_wr = wr & hit_mode & lo_be;
  wire [2:0] new_mode = writedata_in[MODE_POS +: 3];
  wire mode_flush = mode_wr & must_flush(mode, new_mode);
  wire flush = ovr_clear | mode_flush;
  // in rx only the shifter fills the buffer, elsewhere only the host
  wire push_req = is_rx ? rx_byte_ready : fifo_host_wr;
  wire [7:0] push_byte = is_rx ? rx_byte : writedata_in[7:0];
  // a byte lost in the same cycle as a clear still leaves the flag set
  wire overrun_evt = push_req & full;
  wire push = push_req & ~full & ~flush;
  wire tx_load = is_tx & packet_mode & (tx_left == 4'h0) & ~empty & ~fifo_host_rd & ~flush;
  wire pop = ((fifo_host_rd & ~empty) | tx_load) & ~flush;
  wire [CW-1:0] next_count = count + CW'(push) - CW'(pop);
  wire last_bit = is_tx & packet_mode & bit_rise & (tx_left == 4'h1) & empty;
  wire leave_rx = mode_wr & is_rx & (new_mode != MODE_RX);
  wire leave_tx = mode_wr & is_tx & (new_mode != MODE_TX);
  wire went_empty = flush | (pop & ~push & (count == CW'(1)));
  wire collect = is_rx & packet_mode & (pattern_match_flag | ~pattern_config[SYNC_ON_BIT]);
  wire sync_enable = pattern_config[SYNC_ON_BIT] & is_rx & (packet_mode | bitsync_on);

  // read-back mux, unmapped offsets read as zero
  wire [5:0] status_word = {pattern_match_flag, frame_transmitted, buffer_level_event,
                            buffer_overrun_flag, buffer_full_status, buffer_has_data};
  wire [31:0] rd_word =
    hit_mode ? {27'h0, bitsync_on, packet_mode, mode} :
    hit_fifo ? {24'h0, empty ? 8'h00 : mem[rd_ptr]} :
    hit_status ? {26'h0, status_word} :
    hit_thresh ? {25'h0, level_threshold} :
    hit_cfg ? {24'h0, pattern_config} :
    hit_lo ? pattern_value[31:0] :
    hit_hi ? pattern_value[63:32] :
    hit_map_a ? {24'h0, pin_map_a} :
    hit_map_b ? {24'h0, pin_map_b} : 32'h0;

  // bus handshake; read data is captured as the request is first seen
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      waitrequest_out <= 1'b1;
      readdata_out <= 32'h0;
    end else begin
      waitrequest_out <= ~start;
      if (start) readdata_out <= rd_word;
    end
  end

  // register writes take effect on the edge that ends the request
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      mode <= MODE_RST;
      packet_mode <= 1'b1;
      bitsync_on <= 1'b0;
      level_threshold <= THRESH_RST;
      pattern_config <= SYNC_CFG_RST;
      pattern_value <= SYNC_VAL_RST;
      pin_map_a <= MAP_RST;
      pin_map_b <= MAP_RST;
    end else if (wr) begin
      if (mode_wr) begin
        mode <= new_mode;
        packet_mode <= writedata_in[PACKET_BIT];
        bitsync_on <= writedata_in[BITSYNC_BIT];
      end
      if (hit_thresh && lo_be) level_threshold <= writedata_in[6:0];
      if (hit_cfg && lo_be) pattern_config <= writedata_in[7:0];
      if (hit_lo) pattern_value[31:0] <= merge(pattern_value[31:0], writedata_in, byteenable_in);
      if (hit_hi) pattern_value[63:32] <= merge(pattern_value[63:32], writedata_in, byteenable_in);
      if (hit_map_a && lo_be) pin_map_a <= writedata_in[7:0];
      if (hit_map_b && lo_be) pin_map_b <= writedata_in[7:0];
    end
  end

  // storage itself needs no reset; pointers define what is valid
  always_ff @(posedge clk_in) begin
    if (push) mem[wr_ptr] <= push_byte;
  end

  // pointers and fill count
  always_ff @(posedge clk_in) begin
    if (!rstn_in || flush) begin
      count <= '0;
      rd_ptr <= '0;
      wr_ptr <= '0;
    end else begin
      if (push) wr_ptr <= bump(wr_ptr);
      if (pop) rd_ptr <= bump(rd_ptr);
      count <= next_count;
    end
  end

  // status flags; an event always wins over a clear in the same cycle
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      buffer_has_data <= 1'b0;
      buffer_full_status <= 1'b0;
      buffer_overrun_flag <= 1'b0;
      frame_transmitted <= 1'b0;
      pattern_match_flag <= 1'b0;
    end else begin
      // held through the completing read so the host sees a stable answer
      if (!fifo_host_rd) buffer_has_data <= ~empty;
      buffer_full_status <= full;
      if (overrun_evt) buffer_overrun_flag <= 1'b1;
      else if (ovr_clear) buffer_overrun_flag <= 1'b0;
      if (last_bit) frame_transmitted <= 1'b1;
      else if (leave_tx) frame_transmitted <= 1'b0;
      if (pattern_match_event) pattern_match_flag <= 1'b1;
      else if (leave_rx || went_empty) pattern_match_flag <= 1'b0;
    end
  end

  // level event moves only with buffer traffic, frozen after a fill
  always_ff @(posedge clk_in) begin
    if (!rstn_in || flush) begin
      buffer_level_event <= 1'b0;
      level_stale <= 1'b0;
    end else if (push || pop) begin
      level_stale <= (next_count == CW'(DEPTH)) | (level_stale & next_count != '0);
      if (!level_stale || next_count == '0) begin
        buffer_level_event <= next_count > CW'(level_threshold);
      end
    end
  end

  // two flops on every link input before anything looks at it
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      lnk_meta <= 4'h0;
      lnk_sync <= 4'h0;
      lnk_clk_prev <= 1'b0;
    end else begin
      lnk_meta <= {gp_pin_2_in, ref_clk_in, demod_bit_in, bit_clk_in};
      lnk_sync <= lnk_meta;
      lnk_clk_prev <= lnk_sync[0];
    end
  end

  // transmit shifter, msb first on each bit clock rise
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      tx_sr <= 8'h00;
      tx_left <= 4'h0;
      mod_bit_out <= 1'b0;
    end else if (!is_tx) begin
      tx_left <= 4'h0;
    end else if (tx_load) begin
      tx_sr <= mem[rd_ptr];
      tx_left <= 4'h8;
    end else if (bit_rise) begin
      if (!packet_mode) begin
        mod_bit_out <= lnk_sync[3];
      end else if (tx_left != 4'h0) begin
        mod_bit_out <= tx_sr[7];
        tx_sr <= {tx_sr[6:0], 1'b0};
        tx_left <= tx_left - 4'h1;
      end
    end
  end

  // receive shifter packs bytes once the pattern has been seen
  always_ff @(posedge clk_in) begin
    if (!rstn_in || !collect) begin
      rx_sr <= 8'h00;
      rx_cnt <= 3'h0;
      rx_byte <= 8'h00;
      rx_byte_ready <= 1'b0;
    end else begin
      rx_byte_ready <= bit_rise & (rx_cnt == 3'h7);
      if (bit_rise) begin
        rx_sr <= {rx_sr[6:0], rx_bit};
        rx_cnt <= rx_cnt + 3'h1;
        if (rx_cnt == 3'h7) rx_byte <= {rx_sr[6:0], rx_bit};
      end
    end
  end

  pattern_matcher #(
    .MAX_BITS(64)
  ) u_matcher (
    .clk_in(clk_in),
    .rstn_in(rstn_in),
    .enable_in(sync_enable),
    .bit_valid_in(bit_rise),
    .bit_in(rx_bit),
    .length_in(pattern_config[SYNC_LEN_POS +: 3]),
    .tol_in(pattern_config[SYNC_TOL_POS +: 3]),
    .pattern_in(pattern_value),
    .match_out(pattern_match_event)
  );

  // pin codes
  wire [1:0] c0 = pin_map_a[MAP0_POS +: 2];
  wire [1:0] c1 = pin_map_a[MAP1_POS +: 2];
  wire [1:0] c2 = pin_map_a[MAP2_POS +: 2];
  wire [1:0] c3 = pin_map_a[MAP3_POS +: 2];
  wire [1:0] c4 = pin_map_b[MAP4_POS +: 2];
  wire [1:0] c5 = pin_map_b[MAP5_POS +: 2];
  wire refclk = lnk_sync[2] & ~is_sl;
  wire lock = synthesizer_locked_in & (is_fs | is_rx | is_tx);
  wire rdy = is_rx ? receiver_ready_in : is_tx & transmitter_ready_in;
  wire to_tr = is_rx ? timeout_in : is_tx & transmitter_ready_in;
  wire mevt = is_rx & pattern_match_event;
  wire lk_m = is_rx ? pattern_match_event : (is_fs | is_tx) & synthesizer_locked_in;
  wire auto_on = automatic_sequence_active_in;
  wire settled = mode_settled_in;

  // continuous mode selection, codes ordered {11,10,01,00}
  wire [5:0] cont;
  assign cont[5] = pick(c5, {settled, 1'b0, is_tx ? refclk : is_rx & rssi_in, refclk});
  assign cont[4] = pick(c4, {lock, mevt, rdy, to_tr});
  assign cont[3] = pick(c3, {to_tr, auto_on, rdy, is_rx ? rssi_in : is_tx & transmitter_ready_in});
  assign cont[2] = is_rx & rx_bit;
  assign cont[1] = pick(c1, {lk_m, 1'b0, rdy, (is_rx | is_tx) & lnk_sync[0]});
  assign cont[0] = pick(c0, {settled, is_rx & rssi_in, to_tr, lk_m});

  // packet mode selection around the buffer events
  wire [5:0] pkt;
  assign pkt[5] = pick(c5, {settled, 1'b0, 1'b0, refclk});
  assign pkt[4] = pick(c4, {lock, is_rx & receiver_ready_in, is_tx & transmitter_ready_in,
                            is_rx ? timeout_in : is_tx & settled});
  assign pkt[3] = pick(c3, {lock, mevt, rdy | (is_rx & rssi_in), buffer_full_status});
  assign pkt[2] = pick(c2, {auto_on, 1'b0, 1'b0, buffer_has_data});
  assign pkt[1] = pick(c1, {is_rx ? timeout_in : lock, buffer_has_data, buffer_full_status,
                            buffer_level_event});
  assign pkt[0] = pick(c0, {is_rx ? rssi_in : lock, mevt, is_tx & transmitter_ready_in,
                            is_tx & frame_transmitted});
  wire [5:0] pins = packet_mode ? pkt : cont;

  // registered pin drivers; pin 2 turns round to input in continuous tx
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      {gp_pin_5_out, gp_pin_4_out, gp_pin_3_out} <= 3'h0;
      {gp_pin_2_out, gp_pin_1_out, gp_pin_0_out} <= 3'h0;
      gp_pin_2_oe_out <= 1'b0;
    end else begin
      {gp_pin_5_out, gp_pin_4_out, gp_pin_3_out} <= pins[5:3];
      {gp_pin_2_out, gp_pin_1_out, gp_pin_0_out} <= pins[2:0];
      gp_pin_2_oe_out <= packet_mode | ~is_tx;
    end
  end

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  property p_has_data;
    !$past(fifo_host_rd) |-> buffer_has_data == ($past(count) != '0);
  endproperty
  a_has_data: assert property (p_has_data) else $error("has-data wrong");
  property p_read_hold;
    fifo_host_rd |=> $stable(buffer_has_data);
  endproperty
  a_read_hold: assert property (p_read_hold) else $error("has-data moved");
  property p_full;
    push && next_count == CW'(DEPTH) |=> ##1 buffer_full_status;
  endproperty
  a_full: assert property (p_full) else $error("full missing");
  property p_overrun;
    overrun_evt |=> buffer_overrun_flag && count <= $past(count);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun lost");
  property p_clear;
    ovr_clear |=> count == '0 ##1 !buffer_full_status;
  endproperty
  a_clear: assert property (p_clear) else $error("clear kept data");
  property p_sent;
    last_bit |=> frame_transmitted;
  endproperty
  a_sent: assert property (p_sent) else $error("frame-sent missing");
  property p_level;
    !push && !pop && !flush |=> $stable(buffer_level_event);
  endproperty
  a_level: assert property (p_level) else $error("level moved");
  property p_rx_tx;
    mode_wr && is_rx && new_mode == MODE_TX |=> count == '0;
  endproperty
  a_rx_tx: assert property (p_rx_tx) else $error("rx to tx kept data");
  property p_rx_keep;
    mode_wr && is_rx && new_mode == MODE_STDBY && !push && !pop |=> $stable(count);
  endproperty
  a_rx_keep: assert property (p_rx_keep) else $error("rx exit lost data");
  property p_match_clr;
    leave_rx && !pattern_match_event |=> !pattern_match_flag;
  endproperty
  a_match_clr: assert property (p_match_clr) else $error("match kept");

  c_overrun: cover property (overrun_evt);
  c_sent: cover property (last_bit ##1 frame_transmitted);
  c_match: cover property (pattern_match_event && collect == 1'b0);
  c_flush: cover property (mode_flush && !empty);
endmodule : radio_fifo_sync_dio_status
`default_nettype wire

// [logic/radio_pkg.sv]
package radio_pkg;
  // buffer geometry
  localparam int FIFO_DEPTH = 66;
  localparam int ADDR_W = 6;

  // register byte offsets on the avalon slave
  localparam logic [5:0] OFS_MODE = 6'h00;
  localparam logic [5:0] OFS_FIFO = 6'h04;
  localparam logic [5:0] OFS_STATUS = 6'h08;
  localparam logic [5:0] OFS_THRESH = 6'h0c;
  localparam logic [5:0] OFS_SYNC_CFG = 6'h10;
  localparam logic [5:0] OFS_SYNC_LO = 6'h14;
  localparam logic [5:0] OFS_SYNC_HI = 6'h18;
  localparam logic [5:0] OFS_MAP_A = 6'h1c;
  localparam logic [5:0] OFS_MAP_B = 6'h20;

  // mode register fields
  localparam int MODE_POS = 0;
  localparam int PACKET_BIT = 3;
  localparam int BITSYNC_BIT = 4;

  // status register fields
  localparam int ST_HAS_DATA = 0;
  localparam int ST_FULL = 1;
  localparam int ST_OVERRUN = 2;
  localparam int ST_LEVEL = 3;
  localparam int ST_SENT = 4;
  localparam int ST_MATCH = 5;

  // pattern config fields
  localparam int SYNC_ON_BIT = 7;
  localparam int SYNC_LEN_POS = 3;
  localparam int SYNC_TOL_POS = 0;

  // pin map code positions
  localparam int MAP0_POS = 6;
  localparam int MAP1_POS = 4;
  localparam int MAP2_POS = 2;
  localparam int MAP3_POS = 0;
  localparam int MAP4_POS = 6;
  localparam int MAP5_POS = 4;

  // reset values
  localparam logic [2:0] MODE_RST = 3'h1;
  localparam logic [6:0] THRESH_RST = 7'h0f;
  localparam logic [7:0] SYNC_CFG_RST = 8'h98;
  localparam logic [63:0] SYNC_VAL_RST = 64'h0101010101010101;
  localparam logic [7:0] MAP_RST = 8'h00;

  // operating modes
  typedef enum logic [2:0] {
    MODE_SLEEP = 3'h0,
    MODE_STDBY = 3'h1,
    MODE_FS = 3'h2,
    MODE_TX = 3'h3,
    MODE_RX = 3'h4
  } op_mode_t;
endpackage : radio_pkg

// [tb/bit_link_model.sv]
`timescale 1ns/100ps
`default_nettype none
module bit_link_model (
  output logic bit_clk_out,
  output logic demod_bit_out,
  input wire logic mod_bit_in
);
  // clock stands still outside frames
  initial begin
    bit_clk_out = 1'b0;
    demod_bit_out = 1'b0;
  end
  // one byte each way, msb first; the block launches a bit after each rise,
  // so the modulator bit is taken just before the following fall
  task automatic frame(input logic [7:0] tx_byte, output logic [7:0] rx_byte);
    for (int i = 7; i >= 0; i--) begin
      demod_bit_out = tx_byte[i];
      #200 bit_clk_out = 1'b1;
      #190 rx_byte[i] = mod_bit_in;
      #10 bit_clk_out = 1'b0;
    end
    // released line flips so a stale bit never looks valid
    demod_bit_out = ~demod_bit_out;
    #200;
  endtask : frame
endmodule : bit_link_model
`default_nettype wire

// [tb/radio_fifo_sync_dio_status_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module radio_fifo_sync_dio_status_tb;
  import radio_pkg::*;
  logic clk_in = 0, rstn_in = 0, read = 0, write = 0, ms_d = 0;
  logic [5:0] address = 0;
  logic [31:0] writedata = 0, q, rd_data;
  logic [8:0] rnd = 0;
  logic [7:0] b, got, fifo_q[$];
  logic bit_clk, demod, mod_bit, p0, wait_req;
  logic [3:0] po;
  int errors = 0, num_checks = 0, cycles = 0, thr = 15;
  bit ov, lvl, stale;

  task automatic print_verdict;
    if (errors == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // request stands until waitrequest is seen low at a rising edge
  task automatic bus(bit wr, logic [5:0] a, logic [31:0] d);
    int n = 0;
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    @(posedge clk_in);
    while (wait_req !== 1'b0 && n < 50) begin
      n++;
      @(posedge clk_in);
    end
    // read data taken at the same edge that sees waitrequest low
    q = rd_data;
    if (n >= 50) begin
      errors++;
      print_verdict();
    end
    read <= 1'b0;
    write <= 1'b0;
    // one idle edge so release and the next raise never share a time step
    @(posedge clk_in);
  endtask : bus
  function automatic logic [31:0] st(bit m, bit s);
    return {26'h0, m, s, lvl, ov, fifo_q.size() == FIFO_DEPTH, fifo_q.size() > 0};
  endfunction : st
  // level moves only on buffer access and freezes from full until empty
  task automatic upd;
    if (fifo_q.size() == 0) stale = 0;
    if (!stale) lvl = fifo_q.size() > thr;
    if (fifo_q.size() == FIFO_DEPTH) stale = 1;
  endtask : upd
  task automatic put(logic [7:0] v);
    bus(1, OFS_FIFO, {24'h0, v});
    if (fifo_q.size() < FIFO_DEPTH) fifo_q.push_back(v);
    else ov = 1;
    upd();
  endtask : put
  task automatic pop;
    bus(0, OFS_FIFO, 0);
    chk("buffer data", {24'h0, fifo_q.pop_front()}, q);
    upd();
  endtask : pop
  task automatic stat(bit m, bit s);
    bus(0, OFS_STATUS, 0);
    chk("status", st(m, s), q);
  endtask : stat
  task automatic mode(logic [7:0] v, bit flush);
    bus(1, OFS_MODE, {24'h0, v});
    if (flush) fifo_q.delete();
    if (flush) upd();
  endtask : mode

  always #25 clk_in = ~clk_in;
  // side inputs wander so the pin routing sees live values; hang guard
  always @(posedge clk_in) begin
    rnd <= 9'($urandom);
    ms_d <= rnd[0];
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors++;
      print_verdict();
    end
  end
  radio_fifo_sync_dio_status dut_u (.clk_in(clk_in), .rstn_in(rstn_in), .address_in(address),
    .read_in(read), .write_in(write), .writedata_in(writedata), .byteenable_in(4'hf),
    .readdata_out(rd_data), .waitrequest_out(wait_req), .bit_clk_in(bit_clk),
    .demod_bit_in(demod), .mod_bit_out(mod_bit), .ref_clk_in(rnd[8]),
    .mode_settled_in(rnd[0]), .synthesizer_locked_in(rnd[1]), .receiver_ready_in(rnd[2]),
    .transmitter_ready_in(rnd[3]), .rssi_in(rnd[4]), .timeout_in(rnd[5]),
    .automatic_sequence_active_in(rnd[6]), .gp_pin_2_in(rnd[7]), .gp_pin_0_out(p0),
    .gp_pin_1_out(po[0]), .gp_pin_2_out(), .gp_pin_2_oe_out(po[3]), .gp_pin_3_out(po[1]),
    .gp_pin_4_out(po[2]), .gp_pin_5_out());
  bit_link_model link_u (.bit_clk_out(bit_clk), .demod_bit_out(demod), .mod_bit_in(mod_bit));

  initial begin
    void'($urandom(32'hb7a956fc));
    repeat (10) @(posedge clk_in);
    rstn_in <= 1'b1;
    @(posedge clk_in);
    stat(0, 0);
    bus(0, OFS_MAP_B, 0);
    chk("map b", 0, q);
    bus(0, OFS_THRESH, 0);
    chk("threshold", 32'h0f, q);
    bus(0, 6'h3c, 0);
    chk("unmapped", 0, q);
    // fill past capacity, then drain a few while the flags follow
    repeat (67) begin
      put(8'($urandom));
      stat(0, 0);
    end
    repeat (5) begin
      pop();
      stat(0, 0);
    end
    bus(1, OFS_STATUS, 32'h4);
    fifo_q.delete();
    ov = 0;
    upd();
    stat(0, 0);
    repeat (2) put(8'($urandom));
    thr = 1;
    bus(1, OFS_THRESH, 32'h1);
    stat(0, 0);
    put(8'h3c);
    stat(0, 0);
    mode(8'h08, 0);
    mode(8'h09, 0);
    stat(0, 0);
    mode(8'h0c, 1);
    stat(0, 0);
    // preload in standby, then send it
    b = 8'($urandom);
    mode(8'h09, 0);
    put(b);
    mode(8'h0b, 0);
    link_u.frame(8'h00, got);
    chk("tx bits", b, got);
    void'(fifo_q.pop_front());
    upd();
    stat(0, 1);
    mode(8'h09, 1);
    stat(0, 0);
    // one-byte pattern, one error tolerated
    bus(1, OFS_SYNC_CFG, 32'h81);
    bus(1, OFS_SYNC_HI, 32'ha5010101);
    mode(8'h0c, 1);
    // all-zero lead-in: no sliding window comes within one error of the pattern
    link_u.frame(8'h00, got);
    stat(0, 0);
    link_u.frame(8'ha4, got);
    stat(1, 0);
    b = 8'($urandom);
    link_u.frame(b, got);
    fifo_q.push_back(b);
    upd();
    stat(1, 0);
    mode(8'h09, 0);
    stat(0, 0);
    pop();
    // continuous standby, pin 0 code 11 shows the settled-mode input
    mode(8'h01, 0);
    bus(1, OFS_MAP_A, 32'hc0);
    repeat (20) begin
      @(negedge clk_in);
      chk("pin 0", {31'h0, ms_d}, {31'h0, p0});
      chk("quiet pins", 32'h8, {28'h0, po});
    end
    print_verdict();
  end
endmodule : radio_fifo_sync_dio_status_tb
`default_nettype wire
